// *** rtl/cpd_pwm_top.sv ***
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module cpd_pwm_top (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic rst_i, // Sync reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic time_base_sync_i, // Sync pulse in
  output logic sync_out_o, // Pulse at counter zero
  output logic output_a_o, // Channel A drive
  output logic output_b_o // Channel B drive
);

  cpd_pkg::cpd_ctrl_s ctrl_q;
  logic [15:0] period_q;
  logic [15:0] phase_q;
  logic [31:0] duty_q;
  cpd_pkg::cpd_delay_s delay_q;
  cpd_pkg::cpd_delay_s shadow_q;
  logic [15:0] compare_level_a_q;
  logic src_q;
  logic sync_out_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [15:0] count;
  logic req;
  logic wr_en;
  logic sync_take;
  logic db_load;
  logic [31:0] ctrl_word;
  logic [31:0] delay_word;
  logic [31:0] shadow_word;

  // Bus request decode
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_en = req && wb_we_i && ack_q;

  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] target);
    return adr == target;
  endfunction

  assign ctrl_word = {29'h0000_0000, 1'b0, ctrl_q.master, ctrl_q.enable};
  assign delay_word = delay_q;
  assign shadow_word = shadow_q;

  // Classic cycle: ack one cycle after request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  always_comb begin
    rdat_d = 32'h0000_0000;
    case (wb_adr_i)
      cpd_pkg::ADDR_CTRL: begin
        rdat_d = ctrl_word;
      end
      cpd_pkg::ADDR_PERIOD: begin
        rdat_d = {16'h0000, period_q};
      end
      cpd_pkg::ADDR_PHASE: begin
        rdat_d = {16'h0000, phase_q};
      end
      cpd_pkg::ADDR_DUTY: begin
        rdat_d = duty_q;
      end
      cpd_pkg::ADDR_DELAY: begin
        rdat_d = delay_word;
      end
      cpd_pkg::ADDR_SHADOW: begin
        rdat_d = shadow_word;
      end
      cpd_pkg::ADDR_STATUS: begin
        rdat_d = {compare_level_a_q, count};
      end
      default: begin
        rdat_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (req && !ack_q) begin
      rdat_q <= rdat_d;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q.enable <= cpd_pkg::CTRL_EN_RST;
      ctrl_q.master <= cpd_pkg::CTRL_MASTER_RST;
    end else if (wr_en && hit(wb_adr_i, cpd_pkg::ADDR_CTRL) && wb_sel_i[0]) begin
      ctrl_q.enable <= wb_dat_i[cpd_pkg::CTRL_EN_BIT];
      ctrl_q.master <= wb_dat_i[cpd_pkg::CTRL_MASTER_BIT];
    end
  end

  // Self-clearing copy request for held delays
  assign db_load = wr_en && hit(wb_adr_i, cpd_pkg::ADDR_CTRL) &&
                   wb_sel_i[0] && wb_dat_i[cpd_pkg::CTRL_DBLOAD_BIT];

  // Time-base and duty settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_q <= cpd_pkg::PERIOD_RST;
    end else if (wr_en && hit(wb_adr_i, cpd_pkg::ADDR_PERIOD)) begin
      period_q <= 16'(cpd_pkg::merge_sel({16'h0000, period_q}, wb_dat_i,
                                         wb_sel_i));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= cpd_pkg::PHASE_RST;
    end else if (wr_en && hit(wb_adr_i, cpd_pkg::ADDR_PHASE)) begin
      phase_q <= 16'(cpd_pkg::merge_sel({16'h0000, phase_q}, wb_dat_i,
                                        wb_sel_i));
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_q <= cpd_pkg::DUTY_RST;
    end else if (wr_en && hit(wb_adr_i, cpd_pkg::ADDR_DUTY)) begin
      duty_q <= cpd_pkg::merge_sel(duty_q, wb_dat_i, wb_sel_i);
    end
  end

  // Active delays: direct rewrite or copy from held values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      delay_q.rising <= cpd_pkg::RED_RST;
      delay_q.falling <= cpd_pkg::FED_RST;
    end else if (db_load) begin
      delay_q <= shadow_q;
    end else if (wr_en && hit(wb_adr_i, cpd_pkg::ADDR_DELAY)) begin
      delay_q <= cpd_pkg::merge_sel(delay_q, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shadow_q.rising <= cpd_pkg::RED_RST;
      shadow_q.falling <= cpd_pkg::FED_RST;
    end else if (wr_en && hit(wb_adr_i, cpd_pkg::ADDR_SHADOW)) begin
      shadow_q <= cpd_pkg::merge_sel(shadow_q, wb_dat_i, wb_sel_i);
    end
  end

  // Compare level follows duty and period every cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_level_a_q <= 16'h0000;
    end else begin
      compare_level_a_q <= cpd_pkg::scale_duty(duty_q, period_q);
    end
  end

  // Sync only honoured as slave
  assign sync_take = !ctrl_q.master && time_base_sync_i;

  cpd_time_base u_time_base (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(ctrl_q.enable),
    .load_i(sync_take),
    .phase_i(phase_q),
    .period_i(period_q),
    .count_o(count)
  );

  // Source waveform; zero compare keeps it low for 0% duty
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_q.enable) begin
      src_q <= 1'b0;
    end else if (count == compare_level_a_q) begin
      src_q <= 1'b0;
    end else if (count == 16'h0000) begin
      src_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_out_q <= 1'b0;
    end else begin
      sync_out_q <= ctrl_q.enable && count == 16'h0000;
    end
  end

  assign sync_out_o = sync_out_q;

  cpd_dead_band u_dead_band (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_i(src_q),
    .delay_i(delay_q),
    .output_a_o(output_a_o),
    .output_b_o(output_b_o)
  );

  // Checks
  property p_duty_scale;
    @(posedge clk_i) disable iff (rst_i)
      wr_en && hit(wb_adr_i, cpd_pkg::ADDR_DUTY) && wb_sel_i == 4'hF
      ##1 !wr_en [*2]
      |-> compare_level_a_q == cpd_pkg::scale_duty($past(wb_dat_i, 2),
                                                   period_q);
  endproperty
  a_duty_scale: assert property (p_duty_scale)
    else $error("compare level not scaled from duty");

  property p_master_ignores;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_q.enable && ctrl_q.master && time_base_sync_i &&
      count < period_q ##1 ctrl_q.enable
      |-> count == $past(count) + 16'h0001;
  endproperty
  a_master_ignores: assert property (p_master_ignores)
    else $error("master reacted to sync input");

  property p_slave_sync;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_q.enable && !ctrl_q.master && time_base_sync_i ##1 ctrl_q.enable
      |-> count == $past(phase_q);
  endproperty
  a_slave_sync: assert property (p_slave_sync)
    else $error("slave did not load phase on sync");

  property p_delay_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_en && hit(wb_adr_i, cpd_pkg::ADDR_DELAY) && wb_sel_i == 4'hF
      |=> delay_q == $past(wb_dat_i);
  endproperty
  a_delay_write: assert property (p_delay_write)
    else $error("new delays not applied");

  property p_delay_copy;
    @(posedge clk_i) disable iff (rst_i)
      db_load |=> delay_q == $past(shadow_q);
  endproperty
  a_delay_copy: assert property (p_delay_copy)
    else $error("held delays not copied");

  property p_src_zero;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_q.enable && count == 16'h0000 && compare_level_a_q != 16'h0000
      ##1 ctrl_q.enable |-> src_q;
  endproperty
  a_src_zero: assert property (p_src_zero)
    else $error("source not set at counter zero");

  property p_src_match;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_q.enable && count == compare_level_a_q |=> !src_q;
  endproperty
  a_src_match: assert property (p_src_match)
    else $error("source not cleared at compare match");

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i)
      ack_q |=> !ack_q;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack held longer than one cycle");

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
      req && !ack_q |=> ack_q;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not acknowledged next cycle");

  property p_period_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_en && hit(wb_adr_i, cpd_pkg::ADDR_PERIOD) && wb_sel_i == 4'hF
      |=> period_q == $past(wb_dat_i[15:0]);
  endproperty
  a_period_write: assert property (p_period_write)
    else $error("period not written");

  property p_phase_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_en && hit(wb_adr_i, cpd_pkg::ADDR_PHASE) && wb_sel_i == 4'hF
      |=> phase_q == $past(wb_dat_i[15:0]);
  endproperty
  a_phase_write: assert property (p_phase_write)
    else $error("phase offset not written");

  property p_shadow_write;
    @(posedge clk_i) disable iff (rst_i)
      wr_en && hit(wb_adr_i, cpd_pkg::ADDR_SHADOW) && wb_sel_i == 4'hF
      |=> shadow_q == $past(wb_dat_i);
  endproperty
  a_shadow_write: assert property (p_shadow_write)
    else $error("held delays not written");

  property p_sync_out;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_q.enable && count == 16'h0000 |=> sync_out_q;
  endproperty
  a_sync_out: assert property (p_sync_out)
    else $error("no sync pulse after counter zero");

  property p_sync_quiet;
    @(posedge clk_i) disable iff (rst_i)
      !(ctrl_q.enable && count == 16'h0000) |=> !sync_out_q;
  endproperty
  a_sync_quiet: assert property (p_sync_quiet)
    else $error("sync pulse without counter zero");

  property p_disabled_idle;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl_q.enable |=> count == 16'h0000 && !src_q;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("counter or source ran while disabled");

  property p_a_off;
    @(posedge clk_i) disable iff (rst_i)
      !src_q |=> !output_a_o;
  endproperty
  a_a_off: assert property (p_a_off)
    else $error("output A on while source low");

  property p_b_off;
    @(posedge clk_i) disable iff (rst_i)
      src_q |=> !output_b_o;
  endproperty
  a_b_off: assert property (p_b_off)
    else $error("output B on while source high");

  c_slave_sync: cover property (@(posedge clk_i) disable iff (rst_i)
    ctrl_q.enable && sync_take);
  c_db_load: cover property (@(posedge clk_i) disable iff (rst_i)
    db_load && ctrl_q.enable);
  c_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
    ctrl_q.enable && count == period_q ##1 count == 16'h0000);

endmodule // cpd_pwm_top

// *** rtl/cpd_pkg.sv ***
// Function
// - Duty Q24 times period gives integer compare level for output A.
// - Time-base counter counts up only, from zero to period, then restarts.
// - Period value is the highest count reached each switching cycle.
// - Master setting 1: sync input pulses are ignored.
// - Master setting 0: block is slave and obeys sync input pulses.
// - Slave sync loads phase offset into counter; master ignores phase.
// - Output B is complement of source; dead band on both outputs.
// - Falling-edge delay postpones the rising edge of output B.
// - Output A active-high duty, output B complementary active-high duty.
// - Delays may be rewritten while running and replace initial values.
// - Fast path copies held rising and falling delays into active delays.
package cpd_pkg;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_PHASE = 8'h08;
  localparam logic [7:0] ADDR_DUTY = 8'h0C;
  localparam logic [7:0] ADDR_DELAY = 8'h10;
  localparam logic [7:0] ADDR_SHADOW = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MASTER_BIT = 1;
  localparam int unsigned CTRL_DBLOAD_BIT = 2;
  localparam int unsigned DUTY_FRAC_BITS = 24;

  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic CTRL_MASTER_RST = 1'b1;
  localparam logic [15:0] PERIOD_RST = 16'h0257;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [31:0] DUTY_RST = 32'h0000_0000;
  localparam logic [15:0] RED_RST = 16'h0005;
  localparam logic [15:0] FED_RST = 16'h0004;

  typedef struct packed {
    logic [15:0] falling;
    logic [15:0] rising;
  } cpd_delay_s;

  typedef struct packed {
    logic master;
    logic enable;
  } cpd_ctrl_s;

  // Q24 fraction times period, integer part kept
  function automatic logic [15:0] scale_duty(input logic [31:0] duty,
                                             input logic [15:0] period);
    logic [47:0] prod;
    prod = duty * period;
    return prod[DUTY_FRAC_BITS +: 16];
  endfunction

  // Byte-lane merge for Wishbone sel
  function automatic logic [31:0] merge_sel(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    return res;
  endfunction

endpackage

// *** rtl/cpd_time_base.sv ***
`timescale 1ns/1ps
module cpd_time_base (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic enable_i, // Counter runs
  input wire logic load_i, // Load phase this cycle
  input wire logic [15:0] phase_i, // Phase offset
  input wire logic [15:0] period_i, // Top count
  output logic [15:0] count_o // Counter value
);

  logic [15:0] count_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      count_q <= 16'h0000;
    end else if (load_i) begin
      count_q <= phase_i;
    end else if (count_q >= period_i) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_q + 16'h0001;
    end
  end

  assign count_o = count_q;

  property p_count_up;
    @(posedge clk_i) disable iff (rst_i)
      enable_i && !load_i && count_q < period_i
      |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter did not step up by one");

  property p_top_wrap;
    @(posedge clk_i) disable iff (rst_i)
      enable_i && !load_i && count_q == period_i ##1 enable_i
      |-> count_q == 16'h0000;
  endproperty
  a_top_wrap: assert property (p_top_wrap)
    else $error("counter did not restart after period");

  property p_phase_load;
    @(posedge clk_i) disable iff (rst_i)
      enable_i && load_i ##1 enable_i |-> count_q == $past(phase_i);
  endproperty
  a_phase_load: assert property (p_phase_load)
    else $error("phase offset not loaded");

endmodule // cpd_time_base

// *** rtl/cpd_dead_band.sv ***
`timescale 1ns/1ps
module cpd_dead_band (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic src_i, // Channel A source
  input wire cpd_pkg::cpd_delay_s delay_i, // Active delays
  output logic output_a_o, // High-side drive
  output logic output_b_o // Complementary drive
);

  logic [15:0] run_a_q;
  logic [15:0] run_b_q;
  logic out_a_q;
  logic out_b_q;

  // Cycles the source has held its level, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || !src_i) begin
      run_a_q <= 16'h0000;
    end else if (run_a_q != 16'hFFFF) begin
      run_a_q <= run_a_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || src_i) begin
      run_b_q <= 16'h0000;
    end else if (run_b_q != 16'hFFFF) begin
      run_b_q <= run_b_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else begin
      out_a_q <= src_i && (run_a_q >= delay_i.rising);
      out_b_q <= !src_i && (run_b_q >= delay_i.falling);
    end
  end

  assign output_a_o = out_a_q;
  assign output_b_o = out_b_q;

  property p_no_overlap;
    @(posedge clk_i) disable iff (rst_i)
      !(out_a_q && out_b_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both outputs on together");

  property p_b_rise_delay;
    @(posedge clk_i) disable iff (rst_i)
      $rose(out_b_q) |-> $past(run_b_q) >= $past(delay_i.falling);
  endproperty
  a_b_rise_delay: assert property (p_b_rise_delay)
    else $error("output B rose before falling delay");

  property p_a_follows_src;
    @(posedge clk_i) disable iff (rst_i)
      out_a_q |-> $past(src_i) && $past(run_a_q) >= $past(delay_i.rising);
  endproperty
  a_a_follows_src: assert property (p_a_follows_src)
    else $error("output A high without delayed source");

  c_b_rise: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(out_b_q) && delay_i.falling != 16'h0000);

endmodule // cpd_dead_band

// *** tb/cpd_stage_model.sv ***
`timescale 1ns/1ps
module cpd_stage_model (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic high_on_i, // High-side switch gate
  input wire logic low_on_i, // Low-side switch gate
  output logic [15:0] overlap_o // Cycles with both switches on
);
  // Both switches on at once shorts the rail
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overlap_o <= 16'h0000;
    end else if (high_on_i && low_on_i) begin
      overlap_o <= overlap_o + 16'h0001;
    end
  end
endmodule // cpd_stage_model

// *** tb/cpd_pwm_top_tb_top.sv ***
`timescale 1ns/1ps
module cpd_pwm_top_tb_top;
  localparam int PER = 9;
  localparam int CMP = 4;
  logic clk_i;
  logic rst_i;
  logic cyc;
  logic stb;
  logic we;
  logic sync;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic sync_out;
  logic out_a;
  logic out_b;
  logic [15:0] overlap;
  logic [31:0] r;
  logic [31:0] ha;
  logic [31:0] hb;
  logic [31:0] ns;
  logic [47:0] p;
  int fails;
  int checks_done;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
  logic [31:0] rv [7] = '{32'h0000_0002, 32'h0000_0257, 32'h0000_0000,
    32'h0000_0000, 32'h0004_0005, 32'h0004_0005, 32'h0000_0000};
  logic [31:0] dt [4] = '{32'h0080_0000, 32'h0040_0000, 32'h00FF_FFFF,
    32'h0000_0000};

  cpd_pwm_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .time_base_sync_i(sync),
    .sync_out_o(sync_out), .output_a_o(out_a), .output_b_o(out_b)
  );

  cpd_stage_model stage (
    .clk_i(clk_i), .rst_i(rst_i), .high_on_i(out_a), .low_on_i(out_b),
    .overlap_o(overlap)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; waits for ack with no bound of its own, checks latency of two
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1);
    check("ack latency", 32'(n), 32'h0000_0002);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb_xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  // Counts high samples over two switching periods after settling
  task automatic measure();
    repeat (30) @(posedge clk_i);
    ha = 32'h0;
    hb = 32'h0;
    ns = 32'h0;
    repeat (2 * (PER + 1)) begin
      @(posedge clk_i);
      ha = ha + 32'(out_a === 1'b1);
      hb = hb + 32'(out_b === 1'b1);
      ns = ns + 32'(sync_out === 1'b1);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    summarize();
  end

  initial begin
    fails = 0;
    checks_done = 0;
    rst_i = 1'b1;
    {cyc, stb, we, sync} = 4'h0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], r);
      check("reset value", r, rv[i]);
    end
    wr(cpd_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    rd(cpd_pkg::ADDR_STATUS, r);
    check("status read-only", r, 32'h0000_0000);
    wr(cpd_pkg::ADDR_PERIOD, 32'(PER));
    for (int i = 0; i < 4; i++) begin
      wr(cpd_pkg::ADDR_DUTY, dt[i]);
      rd(cpd_pkg::ADDR_STATUS, r);
      p = {16'h0000, dt[i]} * 48'(PER);
      check("compare level", {16'h0, r[31:16]}, {16'h0, p[39:24]});
    end
    wr(cpd_pkg::ADDR_DUTY, 32'h0080_0000);
    wr(cpd_pkg::ADDR_DELAY, 32'h0002_0001);
    wr(cpd_pkg::ADDR_CTRL, 32'h0000_0003);
    measure();
    check("period pulses", ns, 32'h2);
    check("a high", ha, 32'(2 * (CMP - 1)));
    check("b high", hb, 32'(2 * (PER + 1 - CMP - 2)));
    wr(cpd_pkg::ADDR_SHADOW, 32'h0001_0003);
    wr(cpd_pkg::ADDR_CTRL, 32'h0000_0007);
    rd(cpd_pkg::ADDR_DELAY, r);
    check("copied delays", r, 32'h0001_0003);
    measure();
    check("a high fast", ha, 32'(2 * (CMP - 3)));
    check("b high fast", hb, 32'(2 * (PER + 1 - CMP - 1)));
    wr(cpd_pkg::ADDR_PHASE, 32'h0000_0007);
    sync <= 1'b1;
    measure();
    check("master ignores sync", ns, 32'h2);
    wr(cpd_pkg::ADDR_CTRL, 32'h0000_0001);
    rd(cpd_pkg::ADDR_STATUS, r);
    check("slave phase load", {16'h0, r[15:0]}, 32'h0000_0007);
    measure();
    check("slave held", ns, 32'h0);
    sync <= 1'b0;
    measure();
    check("slave runs", ns, 32'h2);
    wr(cpd_pkg::ADDR_CTRL, 32'h0000_0000);
    measure();
    check("disabled a", ha, 32'h0);
    check("disabled b", hb, 32'(2 * (PER + 1)));
    check("disabled sync", ns, 32'h0);
    check("overlap", {16'h0, overlap}, 32'h0);
    summarize();
  end
endmodule // cpd_pwm_top_tb_top
